// ---- common/pfw_pkg.sv ----
/*
 package for the flash self-write controller: register offsets, control
 field positions, reset values, unlock keys and timing counts.
 assumes a 32-bit apb slave with one aligned word per register.
*/
package pfw_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CONTROL   = 8'h00;
	localparam logic [7:0] OFF_UNLOCK    = 8'h04;
	localparam logic [7:0] OFF_ADDR_LOW  = 8'h08;
	localparam logic [7:0] OFF_ADDR_HIGH = 8'h0c;
	localparam logic [7:0] OFF_WORD_LOW  = 8'h10;
	localparam logic [7:0] OFF_WORD_HIGH = 8'h14;
	localparam logic [7:0] OFF_IRQ_STAT  = 8'h18;
	localparam logic [7:0] OFF_IRQ_MASK  = 8'h1c;
	// control field positions
	localparam int B_READ   = 0;
	localparam int B_WRITE  = 1;
	localparam int B_ENABLE = 2;
	localparam int B_ERROR  = 3;
	localparam int B_ERASE  = 4;
	localparam int B_LATCH  = 5;
	localparam int B_CONFIG_SPACE_SELECT   = 6;
	localparam int B_TOP    = 7;
	// interrupt status bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_RDONE = 1;
	localparam int IRQ_W    = 2;
	// widths and keys
	localparam int ADDR_W = 9;
	localparam int WORD_W = 14;
	localparam int DEPTH  = 512;
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	localparam logic [7:0] CTRL_RESET = 8'h80;
	localparam logic [WORD_W-1:0] WORD_ERASED = 14'h3fff;
	// start must follow the second key within this time
	localparam int CLK_NS = 100;
	localparam int UNLOCK_WINDOW_NS = 800;
	localparam int UNLOCK_CYC = UNLOCK_WINDOW_NS / CLK_NS;
	// program time, counted in cycles
	localparam int PROG_TIME_NS = 2000;
	localparam int PROG_CYC = PROG_TIME_NS / CLK_NS;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_K1   = 4'b0010,
		ST_OPEN = 4'b0100,
		ST_BUSY = 4'b1000
	} pfw_state_e;
endpackage

// ---- src/pfw_unlock.sv ----
/*
 unlock key checker: watches writes to the key register and opens a
 short window after the key pair. assumes one write strobe per access.
*/
`timescale 1ns/1ps
module pfw_unlock
	import pfw_pkg::*;
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// key writes
	input  wire logic       key_we,
	input  wire logic [7:0] key_data,
	// consume the window
	input  wire logic       take,
	// window open
	output logic            unlocked
);
	logic [1:0] st_reg;
	logic [1:0] st_next;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;

	////////////////////////////////////////////////////////////////////
	// key sequence; written values never stored for readback
	always_comb
	begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		if (st_reg == 2'd2)
		begin
			if (cnt_reg == 8'h00 || take)
				st_next = 2'd0;
			else
				cnt_next = cnt_reg - 8'h01;
		end
		if (key_we)
		begin
			if (key_data == KEY_FIRST)
				st_next = 2'd1;
			else if (key_data == KEY_SECOND && st_reg == 2'd1)
			begin
				st_next = 2'd2;
				cnt_next = 8'(UNLOCK_CYC);
			end
			else
				st_next = 2'd0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg <= 2'd0;
			cnt_reg <= 8'h00;
			unlocked <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			unlocked <= (st_next == 2'd2);
		end
	end
endmodule

// ---- src/pfw_array.sv ----
/*
 flash array model in flip-flops: combinational read, word program that
 clears bits only, and full-array erase. erased words read all ones.
*/
`timescale 1ns/1ps
module pfw_array
	import pfw_pkg::*;
(
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// access
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [WORD_W-1:0] wdata,
	input  wire logic              prog,
	input  wire logic              erase,
	// read
	output logic      [WORD_W-1:0] rdata
);
	logic [WORD_W-1:0] mem_reg [DEPTH];

	assign rdata = mem_reg[addr];

	////////////////////////////////////////////////////////////////////
	// one cell per word; erase wins over program
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++)
		begin : g_cell
			logic [WORD_W-1:0] cell_next;
			always_comb
			begin
				cell_next = mem_reg[i];
				if (erase)
					cell_next = WORD_ERASED;
				else if (prog && addr == ADDR_W'(i))
					cell_next = mem_reg[i] & wdata; // flash only clears
			end
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					mem_reg[i] <= WORD_ERASED;
				else
					mem_reg[i] <= cell_next;
			end
		end
	endgenerate
endmodule

// ---- src/pfw_top.sv ----
/*
 flash self-write controller with apb register access, unlock check,
 read, program and erase sequencing and a masked interrupt.
 assumes a single pclk domain and an apb master that holds requests.
// What this block does
// - key register is write-only, never stored
// - erase ignores latch-only-load bit
// - starting program or erase sets error flag
// - unimplemented address/data bits read zero
// - read places addressed word in data registers
// - address is low byte plus one high bit
*/
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module pfw_top
	import pfw_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// interrupt
	output logic             irq
);
	import pfw_pkg::*;

	pfw_state_e st_reg;
	pfw_state_e st_next;
	logic [7:0]        ctrl_reg;
	logic [7:0]        ctrl_next;
	logic [7:0]        adl_reg;
	logic [7:0]        adl_next;
	logic              adh_reg;
	logic              adh_next;
	logic [WORD_W-1:0] word_reg;
	logic [WORD_W-1:0] word_next;
	logic [2:0]        stat_reg;
	logic [2:0]        stat_next;
	logic [2:0]        mask_reg;
	logic [2:0]        mask_next;
	logic [7:0]        tmr_reg;
	logic [7:0]        tmr_next;
	logic [31:0]       rd_next;
	logic              slverr_next;
	logic              pready_next;
	logic [31:0]       prdata_next;
	logic              irq_next;
	logic              wr_acc;
	logic              rd_acc;
	logic              lane0;
	logic              key_we;
	logic              unlocked;
	logic              take;
	logic              arr_prog;
	logic              arr_erase;
	logic [ADDR_W-1:0] arr_addr;
	logic [WORD_W-1:0] arr_rdata;
	logic [2:0]        ev;
	logic              mapped;

	// access phase; zero wait states so every access lands here once
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign lane0 = pstrb[0];
	assign key_we = wr_acc && lane0 && paddr == OFF_UNLOCK;
	assign arr_addr = {adh_reg, adl_reg};

	////////////////////////////////////////////////////////////////////
	// unlock checker and flash array
	pfw_unlock u_unlock (
		.pclk     (pclk),
		.presetn  (presetn),
		.key_we   (key_we),
		.key_data (pwdata[7:0]),
		.take     (take),
		.unlocked (unlocked)
	);

	pfw_array u_array (
		.pclk    (pclk),
		.presetn (presetn),
		.addr    (arr_addr),
		.wdata   (word_reg),
		.prog    (arr_prog),
		.erase   (arr_erase),
		.rdata   (arr_rdata)
	);

	always_comb
	begin
		mapped = 1'b1;
		case (paddr)
			OFF_CONTROL, OFF_UNLOCK, OFF_ADDR_LOW, OFF_ADDR_HIGH,
			OFF_WORD_LOW, OFF_WORD_HIGH, OFF_IRQ_STAT, OFF_IRQ_MASK:
				mapped = 1'b1;
			default:
				mapped = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// sequencer and register next values
	always_comb
	begin
		st_next = st_reg;
		ctrl_next = ctrl_reg;
		adl_next = adl_reg;
		adh_next = adh_reg;
		word_next = word_reg;
		mask_next = mask_reg;
		tmr_next = tmr_reg;
		take = 1'b0;
		arr_prog = 1'b0;
		arr_erase = 1'b0;
		ev = 3'b000;
		// software writes to plain fields
		if (wr_acc && lane0)
		begin
			case (paddr)
				OFF_CONTROL:
				begin
					ctrl_next[B_CONFIG_SPACE_SELECT] = pwdata[B_CONFIG_SPACE_SELECT];
					ctrl_next[B_LATCH] = pwdata[B_LATCH];
					ctrl_next[B_ENABLE] = pwdata[B_ENABLE];
					if (st_reg != ST_BUSY)
						ctrl_next[B_ERASE] = pwdata[B_ERASE];
					ctrl_next[B_ERROR] = pwdata[B_ERROR];
				end
				OFF_ADDR_LOW:
					adl_next = pwdata[7:0];
				OFF_ADDR_HIGH:
					adh_next = pwdata[0];
				OFF_WORD_LOW:
					word_next[7:0] = pwdata[7:0];
				OFF_WORD_HIGH:
					word_next[WORD_W-1:8] = pwdata[5:0];
				OFF_IRQ_MASK:
					mask_next = pwdata[2:0];
				default:
				begin
				end
			endcase
		end
		case (st_reg)
			ST_IDLE:
			begin
				if (wr_acc && lane0 && paddr == OFF_CONTROL)
				begin
					// read start, gated by enable
					if (pwdata[B_READ] && !pwdata[B_WRITE] &&
						ctrl_next[B_ENABLE])
						ctrl_next[B_READ] = 1'b1;
					if (pwdata[B_WRITE] && ctrl_next[B_ENABLE])
					begin
						ctrl_next[B_ERROR] = 1'b1;
						if (unlocked)
						begin
							ctrl_next[B_WRITE] = 1'b1;
							take = 1'b1;
							tmr_next = 8'(PROG_CYC);
							st_next = ST_BUSY;
						end
						else
							ev[IRQ_W] = 1'b1;
					end
				end
				if (ctrl_reg[B_READ])
				begin
					word_next = arr_rdata;
					ctrl_next[B_READ] = 1'b0;
					ev[IRQ_RDONE] = 1'b1;
				end
			end
			ST_BUSY:
			begin
				if (tmr_reg != 8'h00)
					tmr_next = tmr_reg - 8'h01;
				else
				begin
					// erase ignores the latch bit
					if (ctrl_reg[B_ERASE])
						arr_erase = 1'b1;
					else if (!ctrl_reg[B_LATCH])
						arr_prog = 1'b1;
					ctrl_next[B_WRITE] = 1'b0;
					ctrl_next[B_ERASE] = 1'b0;
					ctrl_next[B_ERROR] = 1'b0; // normal completion
					ev[IRQ_DONE] = 1'b1;
					st_next = ST_IDLE;
				end
			end
			default:
				st_next = ST_IDLE;
		endcase
		// reserved top bit reads one, start bits not clearable
		ctrl_next[B_TOP] = 1'b1;
	end

	// sticky status: a new event beats a simultaneous clear
	always_comb
	begin
		stat_next = stat_reg;
		if (wr_acc && lane0 && paddr == OFF_IRQ_STAT)
			stat_next = stat_reg & ~pwdata[2:0];
		stat_next = stat_next | ev;
		// level output, follows the status it will hold next
		irq_next = |(stat_next & mask_next);
	end

	// read mux; unused bits read zero
	always_comb
	begin
		rd_next = 32'h0000_0000;
		slverr_next = 1'b0;
		case (paddr)
			OFF_CONTROL:   rd_next[7:0] = ctrl_reg;
			OFF_UNLOCK:    rd_next = 32'h0000_0000;
			OFF_ADDR_LOW:  rd_next[7:0] = adl_reg;
			OFF_ADDR_HIGH: rd_next[0] = adh_reg;
			OFF_WORD_LOW:  rd_next[7:0] = word_reg[7:0];
			OFF_WORD_HIGH: rd_next[5:0] = word_reg[WORD_W-1:8];
			OFF_IRQ_STAT:  rd_next[2:0] = stat_reg;
			OFF_IRQ_MASK:  rd_next[2:0] = mask_reg;
			default:       rd_next = 32'h0000_0000;
		endcase
		if (psel && !penable && !mapped)
			slverr_next = 1'b1;
		// ready registered in setup so access completes in one cycle
		pready_next = psel && !penable;
		// read data captured in setup, held through the access cycle
		prdata_next = prdata;
		if (psel && !penable && !pwrite)
			prdata_next = rd_next;
	end

	////////////////////////////////////////////////////////////////////
	// sequencer and register file
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg <= ST_IDLE;
			ctrl_reg <= CTRL_RESET;
			adl_reg <= 8'h00;
			adh_reg <= 1'b0;
			word_reg <= '0;
			mask_reg <= 3'b000;
			tmr_reg <= 8'h00;
		end
		else
		begin
			st_reg <= st_next;
			ctrl_reg <= ctrl_next;
			adl_reg <= adl_next;
			adh_reg <= adh_next;
			word_reg <= word_next;
			mask_reg <= mask_next;
			tmr_reg <= tmr_next;
		end
	end

	// sticky status and the interrupt level
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stat_reg <= 3'b000;
			irq <= 1'b0;
		end
		else
		begin
			stat_reg <= stat_next;
			irq <= irq_next;
		end
	end

	// bus answer; pready and pslverr one-cycle pulses, prdata held until the next read setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			prdata <= prdata_next;
			pready <= pready_next;
			pslverr <= slverr_next;
		end
	end

	// keep the unused read strobe visible to lint
	logic unused_rd;
	assign unused_rd = rd_acc;
endmodule

// ---- tb/pfw_top_assertions.sv ----
/*
 port checker for the flash self-write controller.
 assumes one pclk domain and zero-wait apb answers.
*/
`timescale 1ns/1ps
module pfw_top_assertions
	import pfw_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	logic rd_ok;
	// read answers on mapped places only
	assign rd_ok = pready && !pwrite && !pslverr;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable;
	endsequence
	answer_time_a: assert property (setup_s ##1 access_s |-> pready)
		else $error("no answer in access cycle");
	ready_qual_a: assert property (pready |-> access_s ##1 !pready)
		else $error("ready outside one access cycle");
	key_zero_a: assert property (
		rd_ok && paddr == OFF_UNLOCK |-> prdata == 32'h0)
		else $error("key register read not zero");
	ctrl_top_a: assert property (
		rd_ok && paddr == OFF_CONTROL |-> prdata[31:7] == 25'h1)
		else $error("control upper bits wrong");
	addr_high_a: assert property (
		rd_ok && paddr == OFF_ADDR_HIGH |-> prdata[31:1] == 31'h0)
		else $error("address high spare bits set");
	word_high_a: assert property (
		rd_ok && paddr == OFF_WORD_HIGH |-> prdata[31:6] == 26'h0)
		else $error("word high spare bits set");
	low_byte_a: assert property (
		rd_ok && (paddr == OFF_ADDR_LOW || paddr == OFF_WORD_LOW)
		|-> prdata[31:8] == 24'h0)
		else $error("low byte register wider than a byte");
	unmapped_a: assert property (pready && paddr > OFF_IRQ_MASK |-> pslverr)
		else $error("unmapped access not flagged");
endmodule

bind pfw_top pfw_top_assertions u_chk (
	.pclk    (pclk),
	.presetn (presetn),
	.psel    (psel),
	.penable (penable),
	.pwrite  (pwrite),
	.paddr   (paddr),
	.prdata  (prdata),
	.pready  (pready),
	.pslverr (pslverr)
);

// ---- tb/pfw_flash_model.sv ----
/*
 behavioural flash array used for expected words.
 assumes the bench calls it once each operation has finished.
*/
`timescale 1ns/1ps
module pfw_flash_model
	import pfw_pkg::*;
;
	logic [WORD_W-1:0] mem [DEPTH];
	// whole array at once, latch bit plays no part
	task automatic erase_all();
		foreach (mem[i]) mem[i] = WORD_ERASED;
	endtask
	// programming only clears bits; 9-bit word index
	task automatic prog(input logic [ADDR_W-1:0] a,
		input logic [WORD_W-1:0] d);
		mem[a] = mem[a] & d;
	endtask
	initial erase_all();
endmodule

// ---- tb/pfw_top_tb.sv ----
/*
 self-checking bench: apb tasks, flash model, refused and good starts.
 assumes zero-wait answers; one idle cycle between transfers.
*/
`timescale 1ns/1ps
module pfw_top_tb;
	import pfw_pkg::*;
	logic              pclk, presetn, psel, penable, pwrite;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, rv;
	logic [3:0]        pstrb;
	logic              pready, pslverr, irq, perr;
	logic [WORD_W-1:0] w;
	int                num_errors, tests_run, cyc;
	pfw_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq));
	pfw_flash_model u_model ();
	always #50 pclk = ~pclk;
	////////////////////////////////////////////////////////////////////
	// one transfer; idle edge after it so drives never collide
	task automatic xfer(input logic [7:0] a, input logic wr,
		input logic [31:0] d);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no cycle count assumed; the hang guard ends a lost answer
		while (pready !== 1'b1)
			@(posedge pclk);
		rv = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h got %h", nm, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		xfer(a, 1'b0, 32'h0);
		chk(nm, e, rv);
	endtask
	// irq is registered: look mid-cycle, resume on a rising edge
	task automatic irq_chk(input logic e);
		@(negedge pclk);
		chk("irq", {31'h0, e}, {31'h0, irq});
		@(posedge pclk);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		xfer(OFF_CONTROL, 1'b0, 32'h0);
		while (rv[1:0] !== 2'b00 && n < 40)
		begin
			xfer(OFF_CONTROL, 1'b0, 32'h0);
			n++;
		end
	endtask
	task automatic keys(input logic [7:0] k1, input logic [7:0] k2);
		xfer(OFF_UNLOCK, 1'b1, {24'h0, k1});
		xfer(OFF_UNLOCK, 1'b1, {24'h0, k2});
	endtask
	task automatic read_word(input logic [ADDR_W-1:0] a);
		xfer(OFF_ADDR_LOW, 1'b1, {24'h0, a[7:0]});
		xfer(OFF_ADDR_HIGH, 1'b1, {31'h0, a[8]});
		xfer(OFF_CONTROL, 1'b1, 32'h05);
		wait_idle();
		w = u_model.mem[a];
		rd(OFF_WORD_LOW, {24'h0, w[7:0]}, "word_low");
		rd(OFF_WORD_HIGH, {26'h0, w[13:8]}, "word_high");
	endtask
	task automatic test_done();
		if (num_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// hang guard, far above the few hundred cycles needed
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////////
	initial
	begin
		{pclk, presetn, psel, penable, pwrite} = 5'h0;
		{paddr, pwdata, num_errors, tests_run, cyc} = '0;
		pstrb = 4'hf;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFF_CONTROL, {24'h0, CTRL_RESET}, "control");
		for (int i = 1; i < 8; i++) rd(8'(i * 4), 32'h0, "zero");
		xfer(8'h20, 1'b0, 32'h0);
		chk("slverr", 32'h1, {31'h0, perr});
		xfer(OFF_ADDR_HIGH, 1'b1, 32'hffffffff);
		rd(OFF_ADDR_HIGH, 32'h1, "addr_high");
		xfer(OFF_WORD_HIGH, 1'b1, 32'hffffffff);
		rd(OFF_WORD_HIGH, 32'h3f, "word_high");
		xfer(OFF_UNLOCK, 1'b1, 32'hff);
		rd(OFF_UNLOCK, 32'h0, "key");
		read_word(9'h1a5);
		rd(OFF_CONTROL, 32'h84, "read_clr");
		rd(OFF_IRQ_STAT, 32'h2, "stat_read");
		xfer(OFF_IRQ_STAT, 1'b1, 32'h7);
		// refused: no enable, then keys reversed
		xfer(OFF_CONTROL, 1'b1, 32'h02);
		rd(OFF_CONTROL, 32'h80, "no_enable");
		keys(KEY_SECOND, KEY_FIRST);
		xfer(OFF_CONTROL, 1'b1, 32'h06);
		rd(OFF_CONTROL, 32'h8c, "bad_keys");
		rd(OFF_IRQ_STAT, 32'h4, "stat_refused");
		xfer(OFF_IRQ_MASK, 1'b1, 32'h4);
		irq_chk(1'b1);
		xfer(OFF_IRQ_STAT, 1'b1, 32'h7);
		irq_chk(1'b0);
		// good program of 0x1234 at 0x1a5
		xfer(OFF_WORD_LOW, 1'b1, 32'h34);
		xfer(OFF_WORD_HIGH, 1'b1, 32'h12);
		keys(KEY_FIRST, KEY_SECOND);
		xfer(OFF_CONTROL, 1'b1, 32'h06);
		rd(OFF_CONTROL, 32'h8e, "busy");
		wait_idle();
		rd(OFF_CONTROL, 32'h84, "prog_done");
		u_model.prog(9'h1a5, 14'h1234);
		read_word(9'h1a5);
		rd(OFF_IRQ_STAT, 32'h3, "stat_done");
		// erase with latch-only-load also set
		keys(KEY_FIRST, KEY_SECOND);
		xfer(OFF_CONTROL, 1'b1, 32'h36);
		wait_idle();
		u_model.erase_all();
		read_word(9'h1a5);
		// start after the key window has run out is refused
		keys(KEY_FIRST, KEY_SECOND);
		repeat (UNLOCK_CYC + 2) @(posedge pclk);
		xfer(OFF_CONTROL, 1'b1, 32'h06);
		rd(OFF_CONTROL, 32'h8c, "late_start");
		rd(OFF_IRQ_STAT, 32'h7, "stat_late");
		// latch-only-load program leaves the array untouched
		xfer(OFF_WORD_LOW, 1'b1, 32'h00);
		xfer(OFF_WORD_HIGH, 1'b1, 32'h00);
		keys(KEY_FIRST, KEY_SECOND);
		xfer(OFF_CONTROL, 1'b1, 32'h26);
		wait_idle();
		rd(OFF_CONTROL, 32'ha4, "latch_done");
		read_word(9'h1a5);
		test_done();
	end
endmodule
